/* design/mfp_strap_led.sv */
// multi-function pins: address straps at reset exit, status LEDs afterwards
`timescale 1ns/10ps
// Notes on behaviour
// - pins are inputs in reset, sampled at exit
// - after sampling, pins become status LED outputs
// - software reset leaves direction and address alone
// - asserted output level is inverse of strap
// - low strap gives address 0, high gives 1
// - activity pin: address bit 0, rx or tx
// - collision pin: address bit 1, collision seen
// - collision indicator held about 70 ms
// - link pin: address bit 2, valid link
// - transmit pin: address bit 3, tx activity
// - receive pin: address bit 4, rx activity
module mfp_strap_led
  import mfp_pkg::*;
#(
  parameter int unsigned COL_CYCLES = COL_STRETCH_CYCLES
) (
  input  wire logic        clock_i,          // device clock, 10 MHz
  input  wire logic        rst_b_i,          // power-on / hardware reset, active low
  input  wire logic        sw_reset_i,       // software reset, ignored here
  input  wire logic        rx_active_i,      // receive activity
  input  wire logic        tx_active_i,      // transmit activity
  input  wire logic        link_ok_i,        // valid link
  input  wire logic        collision_i,      // collision detected
  input  wire mfp_pins_s   pin_i,            // pin levels seen at the pads
  output mfp_pins_s        pin_o,            // pin drive levels
  output mfp_pins_s        pin_oe_o,         // pin output enables, high drives
  output logic [ADDR_W-1:0] strap_address_o, // sampled management address
  output logic             strap_valid_o     // address sampled; pins drive from the next edge
);

  // the stored address and pin direction depend only on rst_b_i
  logic unused_sw_reset;
  assign unused_sw_reset = sw_reset_i;

  function automatic logic led_level(
    input logic asserted, // level that lights the led
    input logic on        // indicator requested
  );
    // an unlit pin returns to its strap level, so no current flows in the led
    return on ? asserted : ~asserted;
  endfunction : led_level

  // used on both the current and the next state
  function automatic logic in_drive(input mfp_state_e st);
    return st == ST_DRIVE;
  endfunction : in_drive

  // one bit per pin, high while its indicator should be lit
  function automatic mfp_pins_s status_on(
    input logic rx,   // receive activity
    input logic tx,   // transmit activity
    input logic link, // valid link
    input logic col   // collision or its hold
  );
    mfp_pins_s on;

    on                     = PINS_RESET;
    on[ADDR_BIT_ACTIVITY]  = rx | tx;
    on[ADDR_BIT_COLLISION] = col;
    on[ADDR_BIT_LINK]      = link;
    on[ADDR_BIT_TRANSMIT]  = tx;
    on[ADDR_BIT_RECEIVE]   = rx;
    return on;
  endfunction : status_on

  // pads are asynchronous to the clock
  mfp_pins_s sync1_r;
  mfp_pins_s sync1_nxt;
  mfp_pins_s sync2_r;
  mfp_pins_s sync2_nxt;

  always_comb begin
    sync1_nxt = pin_i;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= PINS_RESET;
      sync2_r <= PINS_RESET;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  // a one-cycle collision would never show on an led, so it is stretched
  logic col_hold;

  mfp_col_stretch #(
    .CYCLES   (COL_CYCLES)
  ) u_col_stretch (
    .clock_i  (clock_i),
    .rst_b_i  (rst_b_i),
    .trig_i   (collision_i),
    .active_o (col_hold)
  );

  // lit/unlit request per pin, before the polarity is applied
  mfp_pins_s on_now;

  always_comb begin
    on_now = status_on(rx_active_i, tx_active_i, link_ok_i, collision_i | col_hold);
  end

  // sampling sequencer; only a hardware reset brings it back to sampling
  mfp_state_e state_r;
  mfp_state_e state_nxt;
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;

  always_comb begin
    state_nxt  = state_r;
    settle_nxt = settle_r;
    unique case (state_r)
      ST_SAMPLE: begin
        // wait two synchroniser edges; the address is taken on the third edge after release
        if (settle_r == STRAP_SETTLE) begin
          state_nxt = ST_DRIVE;
        end else begin
          settle_nxt = settle_r + 2'h1;
        end
      end
      ST_DRIVE: begin
        // software reset has no path in here, so direction never flips back
        state_nxt = ST_DRIVE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r  <= ST_SAMPLE;
      settle_r <= 2'h0;
    end else begin
      state_r  <= state_nxt;
      settle_r <= settle_nxt;
    end
  end

  // strap capture: address and pin polarity live in separate registers
  // taken once, on the edge that leaves sampling
  logic take_strap;

  always_comb begin
    take_strap = !in_drive(state_r) && (settle_r == STRAP_SETTLE);
  end

  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  mfp_pins_s         pol_r;
  mfp_pins_s         pol_nxt;

  always_comb begin
    addr_nxt = addr_r;
    pol_nxt  = pol_r;
    if (take_strap) begin
      addr_nxt = sync2_r;
      pol_nxt  = ~sync2_r;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_r <= PINS_RESET;
      pol_r  <= PINS_RESET;
    end else begin
      addr_r <= addr_nxt;
      pol_r  <= pol_nxt;
    end
  end

  // pad drivers, registered so the pads never glitch on input changes
  mfp_pins_s out_r;
  mfp_pins_s out_nxt;
  mfp_pins_s oe_r;
  mfp_pins_s oe_nxt;
  logic      valid_r;
  logic      valid_nxt;

  always_comb begin
    out_nxt   = out_r;
    oe_nxt    = oe_r;
    valid_nxt = in_drive(state_nxt);
    unique case (state_r)
      ST_SAMPLE: begin
        // pads stay inputs so the straps are not overdriven
        oe_nxt = PINS_RESET;
      end
      ST_DRIVE: begin
        oe_nxt = PINS_ALL_ON;
        for (int i = 0; i < ADDR_W; i++) begin
          out_nxt[i] = led_level(pol_r[i], on_now[i]);
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r   <= PINS_RESET;
      oe_r    <= PINS_RESET;
      valid_r <= 1'h0;
    end else begin
      out_r   <= out_nxt;
      oe_r    <= oe_nxt;
      valid_r <= valid_nxt;
    end
  end

  // is the board's job: an undriven pad here would read as unknown
  assign pin_o           = out_r;
  assign pin_oe_o        = oe_r;
  assign strap_address_o = addr_r;
  assign strap_valid_o   = valid_r;

endmodule : mfp_strap_led

/* design/mfp_pkg.sv */
// package for the strap-sampled address / status LED pin block
package mfp_pkg;

  // device clock rate and collision LED hold time
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned COL_STRETCH_MS     = 70;
  localparam int unsigned COL_STRETCH_CYCLES = (COL_STRETCH_MS * CLK_HZ) / 1000;

  // edges after reset release before the synchronised pin level is valid
  localparam logic [1:0]  STRAP_SETTLE       = 2'h2;

  // address bit carried by each multi-function pin
  localparam int unsigned ADDR_BIT_ACTIVITY  = 0;
  localparam int unsigned ADDR_BIT_COLLISION = 1;
  localparam int unsigned ADDR_BIT_LINK      = 2;
  localparam int unsigned ADDR_BIT_TRANSMIT  = 3;
  localparam int unsigned ADDR_BIT_RECEIVE   = 4;
  localparam int unsigned ADDR_W             = 5;

  // one bit per multi-function pin; field order makes bit n carry address bit n
  typedef struct packed {
    logic addr4_receive_pin;
    logic addr3_transmit_pin;
    logic addr2_link_pin;
    logic addr1_collision_pin;
    logic addr0_activity_pin;
  } mfp_pins_s;

  localparam mfp_pins_s PINS_RESET  = 5'h00;
  localparam mfp_pins_s PINS_ALL_ON = 5'h1f;

  typedef enum logic [0:0] {
    ST_SAMPLE,
    ST_DRIVE
  } mfp_state_e;

endpackage : mfp_pkg

/* design/mfp_col_stretch.sv */
// retriggerable hold timer for the collision indicator
`timescale 1ns/10ps
module mfp_col_stretch #(
  parameter int unsigned CYCLES = 700000
) (
  input  wire logic clock_i,   // device clock
  input  wire logic rst_b_i,   // async reset, active low
  input  wire logic trig_i,    // collision seen this cycle
  output logic      active_o   // high while the hold runs
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (trig_i) begin
      cnt_nxt = LOAD;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign active_o = (cnt_r != '0);

endmodule : mfp_col_stretch

/* tb/mfp_board.sv */
// board side: pull resistors with series LEDs on the five pins
`timescale 1ns/10ps
module mfp_board
  import mfp_pkg::*;
(
  input  wire mfp_pins_s pull_i, // strap pull levels
  input  wire mfp_pins_s drv_i,  // device drive
  input  wire mfp_pins_s oe_i,   // device enables
  output mfp_pins_s      pad_o   // pad level
);
  // resistor is weak, so a driving device wins
  assign pad_o = (oe_i & drv_i) | (~oe_i & pull_i);
endmodule : mfp_board

/* tb/mfp_strap_led_chk.sv */
// checker for pin direction, strap hold and led levels
`timescale 1ns/10ps
module mfp_strap_led_chk
  import mfp_pkg::*;
#(parameter int unsigned COL_CYCLES = 8) (
  input wire logic clock_i, rst_b_i, rx_active_i, tx_active_i, link_ok_i, collision_i,
  input wire mfp_pins_s pin_o, pin_oe_o,
  input wire logic [ADDR_W-1:0] strap_address_o,
  input wire logic strap_valid_o
);
  int unsigned age_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // saturates past the hold so it never wraps
  always_ff @(posedge clock_i or negedge rst_b_i)
    if (!rst_b_i) age_r <= 0;
    else if (collision_i) age_r <= 1;
    else if (age_r != 0 && age_r <= COL_CYCLES + 1) age_r <= age_r + 1;
  AST_OE_OFF: assert property (!strap_valid_o |-> pin_oe_o == 5'h00)
    else $error("oe early");
  AST_OE_ON: assert property (strap_valid_o |=> pin_oe_o == 5'h1f && strap_valid_o)
    else $error("oe lost");
  AST_ADDR: assert property (strap_valid_o |=> $stable(strap_address_o))
    else $error("addr moved");
  AST_ACT: assert property (pin_oe_o[0] |->
    pin_o[0] == (strap_address_o[0] ^ $past(rx_active_i | tx_active_i))) else $error("act");
  AST_COL: assert property (pin_oe_o[1] |-> pin_o[1] ==
    (strap_address_o[1] ^ (age_r != 0 && age_r <= COL_CYCLES + 1))) else $error("col");
  AST_LNK: assert property (pin_oe_o[2] |->
    pin_o[2] == (strap_address_o[2] ^ $past(link_ok_i))) else $error("link");
  AST_TX: assert property (pin_oe_o[3] |->
    pin_o[3] == (strap_address_o[3] ^ $past(tx_active_i))) else $error("tx");
  AST_RX: assert property (pin_oe_o[4] |->
    pin_o[4] == (strap_address_o[4] ^ $past(rx_active_i))) else $error("rx");
endmodule : mfp_strap_led_chk
bind mfp_strap_led mfp_strap_led_chk #(.COL_CYCLES(COL_CYCLES)) chk_u (.clock_i, .rst_b_i,
  .rx_active_i, .tx_active_i, .link_ok_i, .collision_i, .pin_o, .pin_oe_o, .strap_address_o,
  .strap_valid_o);

/* tb/mfp_strap_led_tb.sv */
// testbench: strap sampling then random status traffic
`timescale 1ns/10ps
module mfp_strap_led_tb;
  import mfp_pkg::*;
  localparam int COL = 8;
  logic clk = 0, rst_b = 0, swr = 0, rx = 0, tx = 0, lnk = 0, col = 0, vld;
  logic [7:0] r = 8'h36;
  logic [4:0] addr, on;
  mfp_pins_s strap = '0, pad, drv, oe;
  int n_errors = 0, num_checks = 0, age;
  mfp_strap_led #(.COL_CYCLES(COL)) dut_u (.clock_i(clk), .rst_b_i(rst_b), .sw_reset_i(swr),
    .rx_active_i(rx), .tx_active_i(tx), .link_ok_i(lnk), .collision_i(col), .pin_i(pad),
    .pin_o(drv), .pin_oe_o(oe), .strap_address_o(addr), .strap_valid_o(vld));
  mfp_board brd_u (.pull_i(strap), .drv_i(drv), .oe_i(oe), .pad_o(pad));
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [4:0] exp_on(input logic rx_v, tx_v, lnk_v, hold_v);
    return {rx_v, tx_v, lnk_v, hold_v, rx_v | tx_v};
  endfunction : exp_on
  task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
    num_checks++;
    if (e !== g) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    for (int k = 0; k < 6; k++) begin
      {rst_b, swr, rx, tx, lnk, col} = '0;
      strap = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : r[4:0];
      repeat (3) @(posedge clk);
      #1 chk("oe_rst", 5'h00, oe);
      rst_b = 1;
      // pads stay inputs while the straps pass the synchroniser
      repeat (2) @(posedge clk);
      #1 chk("oe_smp", 5'h00, oe);
      chk("vld_smp", 5'h00, {4'h0, vld});
      // sampling state lasts up to the third edge after release; pads drive from the fourth
      repeat (2) @(posedge clk);
      #1 chk("oe", 5'h1f, oe);
      chk("vld", 5'h01, {4'h0, vld});
      chk("addr", strap, addr);
      on = '0;
      age = 0;
      for (int c = 0; c < 60; c++) begin
        chk("pin", strap ^ on, drv);
        r = lfsr(r);
        {swr, rx, tx, lnk} = r[3:0];
        col = (r[7:5] == 3'h0);
        @(posedge clk);
        age = col ? 1 : (age != 0 && age <= COL + 1) ? age + 1 : age;
        on = exp_on(rx, tx, lnk, age != 0 && age <= COL + 1);
        #1;
      end
      chk("addr_kept", strap, addr);
      chk("vld_kept", 5'h01, {4'h0, vld});
    end
    report_and_stop();
  end
  initial begin
    #500000;
    n_errors++;
    report_and_stop();
  end
endmodule : mfp_strap_led_tb
